//--- bench/uecr_far.sv
// far-side endpoint model: event pulses and dma requests
`timescale 1ns/1ps
module uecr_far
  import uecr_pkg::*;
(input wire logic clk, go, want, input wire logic [5:0] fire, output uecr_events_t evt, output logic req);
  // a granted beat finishes at once, so done trails go by one cycle
  always_ff @(posedge clk) evt <= fire | {3'h0, go, 2'h0};
  always_ff @(posedge clk) req <= want;
endmodule

//--- bench/uecr_props.sv
// port assertions for the endpoint C register bank
`timescale 1ns/1ps
module uecr_props
  import uecr_pkg::*;
(
  input wire logic             CLK, RST_N, WR, RD, IRQ, DMA_REQ, DMA_GO, HALT_ACTIVE,
  input wire logic [31:0]      ADDR, WDATA, RDATA, DMA_START_ADDRESS,
  input wire logic [LEN_W-1:0] DMA_BYTE_COUNT,
  input wire uecr_events_t     EVENTS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_clr; RD && ADDR == OFS_IRQ_CLEAR |=> RDATA == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear read");
  property p_rsv; RD && ADDR == OFS_IRQ_STATUS |=> RDATA[31:6] == 26'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_go; DMA_GO |-> DMA_REQ && !HALT_ACTIVE; endproperty
  a_go: assert property (p_go) else $error("dma go");
  property p_adr; WR && ADDR == OFS_DMA_ADDRESS |=> DMA_START_ADDRESS == $past(WDATA); endproperty
  a_adr: assert property (p_adr) else $error("dma address");
  property p_len; WR && ADDR == OFS_DMA_LENGTH |=> DMA_BYTE_COUNT == LEN_W'($past(WDATA)); endproperty
  a_len: assert property (p_len) else $error("dma length");
  property p_rise; $rose(IRQ) |-> $past(WR) || $past(EVENTS) != 6'h00; endproperty
  a_rise: assert property (p_rise) else $error("irq rise");
  property p_off; WR && ADDR == OFS_IRQ_CLEAR && WDATA[5:0] == 6'h3F && EVENTS == 6'h00 |=> !IRQ; endproperty
  a_off: assert property (p_off) else $error("irq clear");
  property p_done; EVENTS.done_evt ##1 RD && ADDR == OFS_IRQ_STATUS |=> RDATA[BIT_XFER_DONE]; endproperty
  a_done: assert property (p_done) else $error("done status");
endmodule
bind uecr_regs uecr_props u_uecr_props (.*);

//--- bench/uecr_regs_bench.sv
// self-checking bench for the endpoint C register bank
`timescale 1ns/1ps
module uecr_regs_bench;
  import uecr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, want = 1'b0, irq, go, req, halt;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, dstart, v, seed = 32'h9D30FD7B, q[$];
  logic [LEN_W-1:0] dcount;
  logic [5:0] fire = 6'h00;
  uecr_events_t evt;
  int fails = 0, checks = 0;
  uecr_regs u_uecr_regs (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .IRQ(irq), .EVENTS(evt), .DMA_REQ(req), .DMA_GO(go), .DMA_START_ADDRESS(dstart), .DMA_BYTE_COUNT(dcount),
    .HALT_ACTIVE(halt));
  uecr_far u_uecr_far (.clk(clk), .go(go), .want(want), .fire(fire), .evt(evt), .req(req));
  initial forever #25 clk = ~clk;
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) fails++;
    if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
  endtask
  task end_sim;
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr_t(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task rd_t(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d) check("rdata", rdata, q.pop_front());
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_t(OFS_IRQ_ENABLE + 4 * i, 32'h0);
    v = $random(seed);
    wr_t(OFS_IRQ_ENABLE, v);
    wr_t(OFS_DMA_ADDRESS, v);
    wr_t(OFS_DMA_LENGTH, v);
    wr_t(OFS_IRQ_STATUS, v);
    rd_t(OFS_IRQ_ENABLE, v & 32'h3F);
    rd_t(OFS_DMA_LENGTH, v & 32'hFFFFF);
    rd_t(OFS_IRQ_STATUS, 32'h0);
    check("start", dstart, v);
    wr_t(OFS_IRQ_ENABLE, 32'h3F);
    for (int i = 0; i < 6; i++)
    begin
      fire <= 6'h20 >> i;
      @(posedge clk) fire <= 6'h00;
      rd_t(OFS_IRQ_STATUS, (32'h2 << i) - 1);
    end
    check("irq", irq, 1'b1);
    // the done pulse reaches the bank at the very edge that takes the clear
    fire <= 6'h04;
    @(posedge clk) {addr, wdata, wr, fire} <= {OFS_IRQ_CLEAR, 32'h3F, 1'b1, 6'h00};
    @(posedge clk) wr <= 1'b0;
    rd_t(OFS_IRQ_STATUS, 32'h08);
    wr_t(OFS_IRQ_ENABLE, 32'h37);
    @(negedge clk) check("irq", irq, 1'b0);
    wr_t(OFS_IRQ_CLEAR, 32'h3F);
    rd_t(OFS_IRQ_STATUS, 32'h0);
    wr_t(OFS_EP_CONTROL, 32'h04);
    want <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk) check("go", go, 1'b1);
    wr_t(OFS_EP_CONTROL, 32'h0C);
    @(negedge clk) check("halt", {go, halt}, 2'h1);
    wr_t(OFS_EP_CONTROL, 32'h24);
    @(negedge clk) check("halt", {go, halt}, 2'h2);
    want <= 1'b0;
    rd_t(OFS_IRQ_STATUS, 32'h08);
    repeat (2) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_t(OFS_DMA_ADDRESS, 32'h0);
    rd_t(OFS_EP_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    end_sim;
  end
endmodule

//--- include/uecr_pkg.sv
// package for the endpoint C interrupt and transfer register bank
package uecr_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SRC_N  = 6;
  localparam int LEN_W  = 20;

  // byte addresses of the bank
  localparam logic [31:0] OFS_IRQ_ENABLE  = 32'hFFF06088;
  localparam logic [31:0] OFS_IRQ_CLEAR   = 32'hFFF0608C;
  localparam logic [31:0] OFS_IRQ_STATUS  = 32'hFFF06090;
  localparam logic [31:0] OFS_DMA_ADDRESS = 32'hFFF06094;
  localparam logic [31:0] OFS_DMA_LENGTH  = 32'hFFF06098;
  // endpoint control bits, placed in a register of this block
  localparam logic [31:0] OFS_EP_CONTROL  = 32'hFFF060F0;

  // interrupt source positions
  localparam int BIT_HALT       = 0;
  localparam int BIT_TOKEN_SEEN = 1;
  localparam int BIT_ALT_SET    = 2;
  localparam int BIT_XFER_DONE  = 3;
  localparam int BIT_BUS_FAULT  = 4;
  localparam int BIT_CLR_FEAT   = 5;

  // control register positions
  localparam int BIT_BUFFER_READY  = 2;
  localparam int BIT_HALT_SET      = 3;
  localparam int BIT_HALT_RELEASE  = 5;

  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h00000000;

  typedef struct packed
  {
    logic [SRC_N-1:0]  enable;
    logic [SRC_N-1:0]  status;
    logic [31:0]       dma_address;
    logic [LEN_W-1:0]  dma_length;
    logic              buffer_ready;
    logic              halt;
    logic [31:0]       rdata;
    logic              irq;
  } uecr_state_t;

  // events from the endpoint transfer and DMA logic
  typedef struct packed
  {
    logic halt_evt;
    logic token_evt;
    logic alt_evt;
    logic done_evt;
    logic fault_evt;
    logic clrfeat_evt;
  } uecr_events_t;

endpackage

//--- rtl/uecr_regs.sv
// register bank for endpoint C interrupts, DMA address and length
// Summary of operation
// - six sources at bits 0..5: halt, token, alt setting, done, bus fault, clear feature
// - read-write enable bit per source gates it onto the interrupt
// - write-only clear register, same bit positions as the enables
// - read-only status register shows pending events
// - bus fault on an endpoint bus access sets status bit 4
// - DMA transfer completion sets status bit 3
// - alt setting, token and halt events set status bits 2, 1, 0
// - 32-bit DMA start address register drives the DMA
// - 20-bit DMA byte count, bits 31..20 reserved
// - all five registers reset to zero
// - buffer ready bit must be set before the DMA moves data
// - halt set bit stalls; a separate write-only release bit removes it
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module uecr_regs
  import uecr_pkg::*;
#(
  parameter int SOURCES     = SRC_N,
  parameter int LENGTH_BITS = LEN_W
)
(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic [ADDR_W-1:0]  ADDR,
  input  wire logic [DATA_W-1:0]  WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [DATA_W-1:0]  RDATA,
  output logic                    IRQ,
  input  wire uecr_events_t       EVENTS,
  input  wire logic               DMA_REQ,
  output logic                    DMA_GO,
  output logic      [31:0]        DMA_START_ADDRESS,
  output logic      [LEN_W-1:0]   DMA_BYTE_COUNT,
  output logic                    HALT_ACTIVE
);

  // the state struct is sized from the package, so other sizes are refused
  if (SOURCES != SRC_N)
  begin : g_bad_sources
    $error("uecr_regs: SOURCES differs from the package source count");
  end
  if (LENGTH_BITS != LEN_W)
  begin : g_bad_length
    $error("uecr_regs: LENGTH_BITS differs from the package length width");
  end
  if (SRC_N > DATA_W || LEN_W > DATA_W)
  begin : g_bad_fit
    $error("uecr_regs: a field does not fit the data word");
  end

  // which register a bus cycle names
  typedef enum logic [2:0]
  {
    SEL_NONE    = 3'b000,
    SEL_ENABLE  = 3'b001,
    SEL_CLEAR   = 3'b010,
    SEL_STATUS  = 3'b011,
    SEL_ADDRESS = 3'b100,
    SEL_LENGTH  = 3'b101,
    SEL_CONTROL = 3'b110
  } uecr_sel_t;

  uecr_state_t       st_r;
  uecr_state_t       st_nxt;
  uecr_sel_t         sel;
  logic [SRC_N-1:0]  evt_vec;
  logic [SRC_N-1:0]  clr_vec;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction

  // one decoder serves both the write and the read side
  function automatic uecr_sel_t decode(input logic [ADDR_W-1:0] a);
    uecr_sel_t s;
    s = SEL_NONE;
    if (hit(a, OFS_IRQ_ENABLE))
      s = SEL_ENABLE;
    else if (hit(a, OFS_IRQ_CLEAR))
      s = SEL_CLEAR;
    else if (hit(a, OFS_IRQ_STATUS))
      s = SEL_STATUS;
    else if (hit(a, OFS_DMA_ADDRESS))
      s = SEL_ADDRESS;
    else if (hit(a, OFS_DMA_LENGTH))
      s = SEL_LENGTH;
    else if (hit(a, OFS_EP_CONTROL))
      s = SEL_CONTROL;
    decode = s;
  endfunction

  // reserved bits above a field always read zero
  function automatic logic [DATA_W-1:0] pad_sources(input logic [SRC_N-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[SRC_N-1:0] = v;
    pad_sources = w;
  endfunction

  function automatic logic [DATA_W-1:0] pad_length(input logic [LEN_W-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[LEN_W-1:0] = v;
    pad_length = w;
  endfunction

  function automatic logic [DATA_W-1:0] control_word(input logic ready, input logic halt);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BIT_BUFFER_READY] = ready;
    // the set bit reads back the halt state; the release bit is write-only
    w[BIT_HALT_SET]     = halt;
    control_word = w;
  endfunction

  // endpoint pulses in status bit order
  function automatic logic [SRC_N-1:0] event_bits(input uecr_events_t e);
    logic [SRC_N-1:0] b;
    b = '0;
    b[BIT_HALT]       = e.halt_evt;
    b[BIT_TOKEN_SEEN] = e.token_evt;
    b[BIT_ALT_SET]    = e.alt_evt;
    b[BIT_XFER_DONE]  = e.done_evt;
    b[BIT_BUS_FAULT]  = e.fault_evt;
    b[BIT_CLR_FEAT]   = e.clrfeat_evt;
    event_bits = b;
  endfunction

  // set beats clear, so an event that lands on its own clear is not lost
  function automatic logic [SRC_N-1:0] next_status(
    input logic [SRC_N-1:0] cur,
    input logic [SRC_N-1:0] clr,
    input logic [SRC_N-1:0] evt
  );
    next_status = (cur & ~clr) | evt;
  endfunction

  // release wins over set when software writes both at once
  function automatic logic next_halt(input logic cur, input logic [DATA_W-1:0] w);
    logic h;
    h = cur;
    if (w[BIT_HALT_RELEASE])
      h = 1'b0;
    else if (w[BIT_HALT_SET])
      h = 1'b1;
    next_halt = h;
  endfunction

  function automatic logic any_pending(input logic [SRC_N-1:0] status, input logic [SRC_N-1:0] enable);
    any_pending = |(status & enable);
  endfunction

  always_comb
  begin
    sel     = decode(ADDR);
    evt_vec = event_bits(EVENTS);
    clr_vec = '0;
    if (WR && sel == SEL_CLEAR)
    begin
      clr_vec = WDATA[SRC_N-1:0];
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.status = next_status(st_r.status, clr_vec, evt_vec);

    // status is read-only and the clear register holds no state
    if (WR)
    begin
      unique case (sel)
        SEL_ENABLE:
        begin
          st_nxt.enable = WDATA[SRC_N-1:0];
        end
        SEL_ADDRESS:
        begin
          st_nxt.dma_address = WDATA;
        end
        SEL_LENGTH:
        begin
          st_nxt.dma_length = WDATA[LEN_W-1:0];
        end
        SEL_CONTROL:
        begin
          st_nxt.buffer_ready = WDATA[BIT_BUFFER_READY];
          st_nxt.halt         = next_halt(st_r.halt, WDATA);
        end
        SEL_NONE, SEL_CLEAR, SEL_STATUS:
        begin
        end
      endcase
    end

    // read data stand for one cycle only, then fall back to zero
    st_nxt.rdata = UNMAPPED_VALUE;
    if (RD)
    begin
      unique case (sel)
        SEL_ENABLE:
        begin
          st_nxt.rdata = pad_sources(st_r.enable);
        end
        SEL_STATUS:
        begin
          st_nxt.rdata = pad_sources(st_r.status);
        end
        SEL_ADDRESS:
        begin
          st_nxt.rdata = st_r.dma_address;
        end
        SEL_LENGTH:
        begin
          st_nxt.rdata = pad_length(st_r.dma_length);
        end
        SEL_CONTROL:
        begin
          st_nxt.rdata = control_word(st_r.buffer_ready, st_r.halt);
        end
        SEL_CLEAR:
        begin
          st_nxt.rdata = 32'h00000000;
        end
        SEL_NONE:
        begin
          st_nxt.rdata = UNMAPPED_VALUE;
        end
      endcase
    end

    st_nxt.irq = any_pending(st_nxt.status, st_nxt.enable);
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign RDATA             = st_r.rdata;
  assign IRQ               = st_r.irq;
  assign DMA_START_ADDRESS = st_r.dma_address;
  assign DMA_BYTE_COUNT    = st_r.dma_length;
  assign DMA_GO            = DMA_REQ && st_r.buffer_ready && !st_r.halt;
  assign HALT_ACTIVE       = st_r.halt;

endmodule
